// File: logic/lnbc_pkg.sv
// Contract
// RQ1: sda changes only while scl is low, except start and stop; the port releases sda at any scl level when undervoltage arrives.
// RQ2: sda falling while scl high is a start.
// RQ3: sda rising while scl high is a stop; port returns to idle.
// RQ4: master sends a stop before every new start.
// RQ5: bytes are 8 bits, msb first, each followed by an acknowledge clock.
// RQ6: master releases sda during every acknowledge pulse; after a read byte the host model pulls sda low there to ask for another.
// RQ7: addressed device holds sda low for the whole acknowledge pulse.
// RQ8: on a missing acknowledge the master may stop and abort.
// RQ9: during undervoltage the device never acknowledges or answers.
// RQ10: master may ignore acknowledges and just wait one clock.
// RQ11: address 0001000 with select at ground; bytes 10 write, 11 read.
// RQ12: address byte lsb: 1 reads, 0 writes.
// RQ13: transaction is start, address, ack, one data byte, ack, stop.
// RQ14: address select level picks one of four addresses.
// RQ15: with forced tone low the key input gates the carrier.
// RQ16: tone detect output is open collector, low while tone present.
// RQ17: power enable low closes the loop-through bypass switch.
// RQ18: six writable upper bits, two read-only flags low; all clear at power-on.
// RQ19: writes change only the six writable bits.
// RQ20: read sends register msb first; master ack repeats, nack ends.
// RQ21: scl and sda are synchronised and filtered before edge detection.
package lnbc_pkg;
	localparam int BYTE_MSB = 7;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	localparam logic [6:0] DEV_ADDR_BASE = 7'h08;
	// system_control_reg fields, byte positions
	localparam int SYS_PULSE_LIM = 7;
	localparam int SYS_CUR_SEL = 6;
	localparam int SYS_FORCED_TONE_BIT = 5;
	localparam int SYS_CABLE_COMP = 4;
	localparam int SYS_VOLT_SEL = 3;
	localparam int SYS_POWER_EN = 2;
	localparam int SYS_OVER_TEMP = 1;
	localparam int SYS_OVER_LOAD = 0;
	localparam int SYS_CTRL_LSB = 2;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	// synchroniser lanes in the link domain
	localparam int IN_SCL = 0;
	localparam int IN_SDA = 1;
	localparam int IN_UV = 2;
	localparam int IN_OTF = 3;
	localparam int IN_OLF = 4;
	localparam int IN_ASEL = 5;
	localparam int NIN = 7;
	// lanes in the core domain
	localparam int IN_KEY = 0;
	localparam int IN_SENSE = 1;
	typedef enum logic [2:0] {
		LNBC_IDLE, LNBC_ADDR, LNBC_ACKA, LNBC_WDATA, LNBC_ACKW, LNBC_RDATA, LNBC_RACK
	} lnbc_state_t;
endpackage

// File: logic/lnbc_i2c_slave.sv
`timescale 1ns/1ps
module lnbc_i2c_slave (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        linkClk,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic [1:0]  addrSel,
	input  wire logic        uvloIn,
	input  wire logic        overTempIn,
	input  wire logic        overLoadIn,
	input  wire logic        toneKeyIn,
	input  wire logic        toneSenseIn,
	output logic             toneCarrierOn,
	output logic             toneDetectOut,
	output logic             toneDetectOe,
	output logic             bypassClose,
	output logic [lnbc_pkg::CTRL_W-1:0] ctrlBits
);
	import lnbc_pkg::*;

	typedef struct packed {
		logic [NIN-1:0] s1;
		logic [NIN-1:0] s2;
		logic [NIN-1:0] s3;
		logic [NIN-1:0] f;
		logic           sclP;
		logic           sdaP;
		lnbc_state_t    st;
		logic [3:0]     bitCnt;
		logic [7:0]     shift;
		logic           rw;
		logic           mAck;
		logic           sdaOe;
		logic           sdaOut;
		logic [CTRL_W-1:0] sysCtrl;
		logic           wrTgl;
	} lnbc_link_t;

	typedef struct packed {
		logic [2:0]        tg;
		logic              tgSeen;
		logic [1:0]        k1;
		logic [1:0]        k2;
		logic [1:0]        k3;
		logic [1:0]        kf;
		logic [CTRL_W-1:0] ctrl;
		logic              toneOn;
		logic              detOe;
		logic              detOut;
		logic              bypass;
	} lnbc_core_t;

	lnbc_link_t l_reg;
	lnbc_link_t l_next;
	lnbc_core_t c_reg;
	lnbc_core_t c_next;

	logic       sclRise;
	logic       sclFall;
	logic       startEv;
	logic       stopEv;
	logic       uv;
	logic [6:0] myAddr;
	logic [7:0] readByte;

	// ---------------- link domain ----------------
	assign sclRise = l_reg.f[IN_SCL] & ~l_reg.sclP;
	assign sclFall = ~l_reg.f[IN_SCL] & l_reg.sclP;
	assign startEv = l_reg.f[IN_SCL] & l_reg.sclP & l_reg.sdaP & ~l_reg.f[IN_SDA]; // RQ2
	assign stopEv = l_reg.f[IN_SCL] & l_reg.sclP & ~l_reg.sdaP & l_reg.f[IN_SDA]; // RQ3
	assign uv = l_reg.f[IN_UV];
	assign myAddr = DEV_ADDR_BASE | 7'({l_reg.f[IN_ASEL+1:IN_ASEL], 1'b0}); // RQ11 RQ14
	assign readByte = {l_reg.sysCtrl, l_reg.f[IN_OTF], l_reg.f[IN_OLF]}; // RQ18

	always_comb begin
		l_next = l_reg;
		l_next.s1 = {addrSel, overLoadIn, overTempIn, uvloIn, sdaIn, sclIn};
		l_next.s2 = l_reg.s1;
		l_next.s3 = l_reg.s2;
		// a lane moves only once the second and third stages agree
		l_next.f = (l_reg.s2 & ~(l_reg.s2 ^ l_reg.s3)) | (l_reg.f & (l_reg.s2 ^ l_reg.s3)); // RQ21
		l_next.sclP = l_reg.f[IN_SCL];
		l_next.sdaP = l_reg.f[IN_SDA];
		unique case (l_reg.st)
			LNBC_IDLE: ;
			LNBC_ADDR, LNBC_WDATA: begin
				if (sclRise) begin // RQ5
					l_next.shift = {l_reg.shift[BYTE_MSB-1:0], l_reg.f[IN_SDA]};
					l_next.bitCnt = l_reg.bitCnt + 4'h1;
				end
				if (sclFall && l_reg.bitCnt == BITS_PER_BYTE) begin
					if (l_reg.st == LNBC_WDATA) begin
						l_next.sysCtrl = l_reg.shift[BYTE_MSB:SYS_CTRL_LSB]; // RQ19
						l_next.wrTgl = ~l_reg.wrTgl;
						l_next.sdaOe = 1'b1; // RQ7
						l_next.st = LNBC_ACKW;
					end else if (l_reg.shift[BYTE_MSB:1] == myAddr) begin // RQ11
						l_next.rw = l_reg.shift[0]; // RQ12
						l_next.sdaOe = 1'b1; // RQ7
						l_next.st = LNBC_ACKA;
					end else begin
						l_next.st = LNBC_IDLE;
					end
				end
			end
			LNBC_ACKA: begin
				if (sclFall) begin
					l_next.bitCnt = BIT_CNT_RST;
					if (l_reg.rw) begin // RQ12
						l_next.shift = readByte;
						l_next.sdaOe = ~readByte[BYTE_MSB]; // RQ20
						l_next.st = LNBC_RDATA;
					end else begin
						l_next.sdaOe = 1'b0;
						l_next.st = LNBC_WDATA; // RQ13
					end
				end
			end
			LNBC_ACKW: begin
				if (sclFall) begin
					l_next.sdaOe = 1'b0;
					l_next.bitCnt = BIT_CNT_RST;
					l_next.st = LNBC_WDATA;
				end
			end
			LNBC_RDATA: begin
				if (sclFall) begin
					if (l_reg.bitCnt == LAST_TX_BIT) begin
						l_next.sdaOe = 1'b0;
						l_next.st = LNBC_RACK;
					end else begin
						l_next.bitCnt = l_reg.bitCnt + 4'h1;
						l_next.shift = {l_reg.shift[BYTE_MSB-1:0], 1'b0};
						l_next.sdaOe = ~l_reg.shift[BYTE_MSB-1]; // RQ20
					end
				end
			end
			LNBC_RACK: begin
				if (sclRise) begin
					l_next.mAck = ~l_reg.f[IN_SDA];
				end
				if (sclFall) begin
					if (l_reg.mAck) begin // RQ20
						l_next.bitCnt = BIT_CNT_RST;
						l_next.shift = readByte;
						l_next.sdaOe = ~readByte[BYTE_MSB];
						l_next.st = LNBC_RDATA;
					end else begin
						l_next.st = LNBC_IDLE;
					end
				end
			end
			default: begin
				l_next.sdaOe = 1'b0;
				l_next.st = LNBC_IDLE;
			end
		endcase
		if (stopEv) begin // RQ3
			l_next.sdaOe = 1'b0;
			l_next.st = LNBC_IDLE;
		end else if (startEv) begin // RQ2
			l_next.sdaOe = 1'b0;
			l_next.bitCnt = BIT_CNT_RST;
			l_next.st = LNBC_ADDR;
		end
		// lockout wins over everything except a write landing while the register is already clear; that value stays one cycle, then clears
		if (uv) begin // RQ9
			l_next.sdaOe = 1'b0;
			l_next.st = LNBC_IDLE;
			if (l_reg.sysCtrl != CTRL_RST) begin
				l_next.sysCtrl = CTRL_RST;
				l_next.wrTgl = ~l_reg.wrTgl;
			end
		end
	end

	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			l_reg <= '0; // RQ18
		end else begin
			l_reg <= l_next;
		end
	end

	assign sdaOe = l_reg.sdaOe;
	assign sdaOut = l_reg.sdaOut;

	// ---------------- core domain ----------------
	// sysCtrl is stable long before the toggle is seen, so the word crosses safely
	always_comb begin
		c_next = c_reg;
		c_next.tg = {c_reg.tg[1:0], l_reg.wrTgl};
		if (c_reg.tg[1] == c_reg.tg[2] && c_reg.tg[2] != c_reg.tgSeen) begin
			c_next.tgSeen = c_reg.tg[2];
			c_next.ctrl = l_reg.sysCtrl;
		end
		c_next.k1 = {toneSenseIn, toneKeyIn};
		c_next.k2 = c_reg.k1;
		c_next.k3 = c_reg.k2;
		c_next.kf = (c_reg.k2 & ~(c_reg.k2 ^ c_reg.k3)) | (c_reg.kf & (c_reg.k2 ^ c_reg.k3));
		c_next.toneOn = c_reg.ctrl[SYS_POWER_EN - SYS_CTRL_LSB]
			& (c_reg.ctrl[SYS_FORCED_TONE_BIT - SYS_CTRL_LSB] | c_reg.kf[IN_KEY]); // RQ15
		c_next.detOe = c_reg.kf[IN_SENSE]; // RQ16
		c_next.bypass = ~c_reg.ctrl[SYS_POWER_EN - SYS_CTRL_LSB]; // RQ17
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end

	assign toneCarrierOn = c_reg.toneOn;
	assign toneDetectOut = c_reg.detOut;
	assign toneDetectOe = c_reg.detOe;
	assign bypassClose = c_reg.bypass;
	assign ctrlBits = c_reg.ctrl;

	// ---------------- checks ----------------
	// link-domain checks look at the synchroniser stages and the filtered bus view, never the raw pins
	a_start_detect: assert property (@(posedge linkClk) disable iff (!resetn) // RQ2
		startEv && !stopEv && !uv |=> l_reg.st == LNBC_ADDR) else $error("start not taken");
	a_start_count: assert property (@(posedge linkClk) disable iff (!resetn) // RQ5
		startEv
		|=> l_reg.bitCnt == BIT_CNT_RST) else $error("start left a bit count");
	a_stop_idle: assert property (@(posedge linkClk) disable iff (!resetn) // RQ3
		stopEv |=> l_reg.st == LNBC_IDLE && !l_reg.sdaOe) else $error("stop not taken");
	a_sda_change: assert property (@(posedge linkClk) disable iff (!resetn) // RQ1
		$rose(l_reg.sdaOe) |-> !l_reg.f[IN_SCL]) else $error("sda driven while scl high");
	a_filter_agree: assert property (@(posedge linkClk) disable iff (!resetn) // RQ21
		l_reg.s2 == l_reg.s3
		|=> l_reg.f == $past(l_reg.s3)) else $error("filter did not follow");
	a_filter_hold: assert property (@(posedge linkClk) disable iff (!resetn) // RQ21
		l_reg.s2[IN_SDA] != l_reg.s3[IN_SDA]
		|=> $stable(l_reg.f[IN_SDA])) else $error("filter passed a glitch");
	a_addr_ack: assert property (@(posedge linkClk) disable iff (!resetn) // RQ7
		l_reg.st == LNBC_ADDR && sclFall && l_reg.bitCnt == BITS_PER_BYTE && l_reg.shift[BYTE_MSB:1] == myAddr && !uv
		|=> l_reg.sdaOe && l_reg.st == LNBC_ACKA) else $error("own address not acknowledged");
	a_ack_hold: assert property (@(posedge linkClk) disable iff (!resetn) // RQ7
		sclRise && (l_reg.st == LNBC_ACKA || l_reg.st == LNBC_ACKW) && !uv && !stopEv
		|-> l_reg.sdaOe) else $error("ack not held");
	a_wdata_next: assert property (@(posedge linkClk) disable iff (!resetn) // RQ13
		l_reg.st == LNBC_ACKW && sclFall && !uv
		|=> l_reg.st == LNBC_WDATA && !l_reg.sdaOe && l_reg.bitCnt == BIT_CNT_RST) else $error("ack not ended");
	a_uv_silent: assert property (@(posedge linkClk) disable iff (!resetn) // RQ9
		uv |=> !l_reg.sdaOe && l_reg.st == LNBC_IDLE) else $error("answer under lockout");
	a_uv_clear: assert property (@(posedge linkClk) disable iff (!resetn) // RQ9
		uv
		|=> l_reg.sysCtrl == CTRL_RST) else $error("register kept under lockout");
	a_addr_miss: assert property (@(posedge linkClk) disable iff (!resetn) // RQ11
		l_reg.st == LNBC_ADDR && sclFall && l_reg.bitCnt == BITS_PER_BYTE
		&& l_reg.shift[BYTE_MSB:1] != myAddr && !startEv |=> !l_reg.sdaOe) else $error("foreign ack");
	a_byte_len: assert property (@(posedge linkClk) disable iff (!resetn) // RQ5
		l_reg.st == LNBC_ACKW && $past(l_reg.st) == LNBC_WDATA
		|-> $past(l_reg.bitCnt) == BITS_PER_BYTE) else $error("byte length wrong");
	a_flags_ro: assert property (@(posedge linkClk) disable iff (!resetn) // RQ19
		l_reg.st == LNBC_ACKW && $past(l_reg.st) == LNBC_WDATA
		|-> l_reg.sysCtrl == 6'($past(l_reg.shift) >> SYS_CTRL_LSB)) else $error("bad write");
	a_rw_dir: assert property (@(posedge linkClk) disable iff (!resetn) // RQ12
		l_reg.st == LNBC_RDATA && $past(l_reg.st) == LNBC_ACKA
		|-> l_reg.rw) else $error("read on write");
	a_read_bit: assert property (@(posedge linkClk) disable iff (!resetn) // RQ20
		l_reg.st == LNBC_RDATA
		|-> l_reg.sdaOe == ~l_reg.shift[BYTE_MSB]) else $error("read bit wrong");
	a_read_count: assert property (@(posedge linkClk) disable iff (!resetn) // RQ5
		l_reg.st == LNBC_RDATA
		|-> l_reg.bitCnt <= LAST_TX_BIT) else $error("read byte too long");
	a_read_release: assert property (@(posedge linkClk) disable iff (!resetn) // RQ20
		l_reg.st == LNBC_RACK
		|-> !l_reg.sdaOe) else $error("sda held in master ack");
	a_nack_end: assert property (@(posedge linkClk) disable iff (!resetn) // RQ20
		l_reg.st == LNBC_RACK && sclFall && !l_reg.mAck && !startEv
		|=> l_reg.st == LNBC_IDLE) else $error("read not ended");

	// core-domain checks; ctrl only moves after the toggle handshake
	a_tone_gate: assert property (@(posedge clk) disable iff (!resetn) // RQ15
		c_reg.ctrl[SYS_POWER_EN - SYS_CTRL_LSB] && !c_reg.ctrl[SYS_FORCED_TONE_BIT - SYS_CTRL_LSB]
		&& $stable(c_reg.ctrl) |=> c_reg.toneOn == $past(c_reg.kf[IN_KEY])) else $error("tone gate");
	a_carrier_off: assert property (@(posedge clk) disable iff (!resetn) // RQ15
		!c_reg.ctrl[SYS_POWER_EN - SYS_CTRL_LSB]
		|=> !toneCarrierOn) else $error("carrier on in standby");
	a_tone_det: assert property (@(posedge clk) disable iff (!resetn) // RQ16
		c_reg.kf[IN_SENSE] |=> toneDetectOe && !toneDetectOut) else $error("detect not low");
	a_det_release: assert property (@(posedge clk) disable iff (!resetn) // RQ16
		!c_reg.kf[IN_SENSE]
		|=> !toneDetectOe) else $error("detect not released");
	a_bypass: assert property (@(posedge clk) disable iff (!resetn) // RQ17
		!c_reg.ctrl[SYS_POWER_EN - SYS_CTRL_LSB] |=> bypassClose) else $error("bypass open");
	a_bypass_open: assert property (@(posedge clk) disable iff (!resetn) // RQ17
		c_reg.ctrl[SYS_POWER_EN - SYS_CTRL_LSB]
		|=> !bypassClose) else $error("bypass closed while powered");

	// traffic shapes that the bench is expected to reach
	c_write: cover property (@(posedge linkClk) disable iff (!resetn) l_reg.st == LNBC_ACKW);
	c_read: cover property (@(posedge linkClk) disable iff (!resetn) l_reg.st == LNBC_RACK && l_reg.mAck);
	c_nack: cover property (@(posedge linkClk) disable iff (!resetn) l_reg.st == LNBC_RACK && sclFall && !l_reg.mAck);
	c_lockout: cover property (@(posedge linkClk) disable iff (!resetn) uv && startEv);
	c_addr_miss: cover property (@(posedge linkClk) disable iff (!resetn) l_reg.st == LNBC_ADDR && sclFall
		&& l_reg.bitCnt == BITS_PER_BYTE && l_reg.shift[BYTE_MSB:1] != myAddr);
endmodule

// File: bench/lnbc_host_model.sv
`timescale 1ns/1ps
module lnbc_host_model (
	input  wire logic linkClk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaDrv
);
	// half clock phase in link cycles, kept above the four the port filter needs
	localparam int H = 8;
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic pause(input int n);
		repeat (n) @(posedge linkClk);
	endtask
	task automatic bitx(input logic b, output logic r);
		sdaDrv <= b;
		pause(H);
		scl <= 1'b1;
		pause(H);
		r = sdaWire;
		scl <= 1'b0;
		// gap after the fall so data never moves together with the clock edge
		pause(2);
	endtask
	task automatic start();
		sdaDrv <= 1'b0;
		pause(H);
		scl <= 1'b0;
		pause(2);
	endtask
	task automatic stop();
		sdaDrv <= 1'b0;
		pause(H);
		scl <= 1'b1;
		pause(H);
		sdaDrv <= 1'b1;
		pause(H);
	endtask
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic rdByte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(~more, r);
	endtask
endmodule

// File: bench/lnb_ctrl_i2c_slave_port_tb_top.sv
`timescale 1ns/1ps
module lnb_ctrl_i2c_slave_port_tb_top;
	import lnbc_pkg::*;
	logic       clk = 1'b0;
	logic       linkClk = 1'b0;
	logic       resetn = 1'b0;
	logic [1:0] addrSel = 2'h0;
	logic       uvloIn = 1'b0;
	logic       overTempIn = 1'b0;
	logic       overLoadIn = 1'b0;
	logic       toneKeyIn = 1'b0;
	logic       toneSenseIn = 1'b0;
	logic       scl, sdaDrv, sdaOut, sdaOe, toneCarrierOn, toneDetectOut, toneDetectOe, bypassClose;
	logic [CTRL_W-1:0] ctrlBits;
	logic [5:0] expCtrl = 6'h00;
	int         n_errors = 0;
	int         check_count = 0;
	// open drain: either party pulling low wins over the pull-up
	wire        sdaWire = (sdaOe ? sdaOut : 1'b1) & sdaDrv;
	always #5 clk = ~clk;
	initial begin
		#17;
		forever #80 linkClk = ~linkClk;
	end
	lnbc_i2c_slave dut_u (.clk(clk), .resetn(resetn), .linkClk(linkClk), .sclIn(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel), .uvloIn(uvloIn), .overTempIn(overTempIn),
		.overLoadIn(overLoadIn), .toneKeyIn(toneKeyIn), .toneSenseIn(toneSenseIn),
		.toneCarrierOn(toneCarrierOn), .toneDetectOut(toneDetectOut), .toneDetectOe(toneDetectOe),
		.bypassClose(bypassClose), .ctrlBits(ctrlBits));
	lnbc_host_model host_u (.linkClk(linkClk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] addrByte(input logic [1:0] s, input logic rd);
		return {DEV_ADDR_BASE | {4'h0, s, 1'b0}, rd};
	endfunction
	task automatic clks(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic doWrite(input logic [1:0] s, input logic [7:0] d);
		logic a;
		host_u.start();
		host_u.wrByte(addrByte(s, 1'b0), a);
		chk({7'h00, a}, 8'h01);
		host_u.wrByte(d, a);
		chk({7'h00, a}, 8'h01);
		host_u.stop();
		clks(10);
		expCtrl = d[7:2];
		chk({2'h0, ctrlBits}, {2'h0, expCtrl});
		chk({7'h00, bypassClose}, {7'h00, ~d[SYS_POWER_EN]});
		chk({7'h00, toneCarrierOn}, {7'h00, d[SYS_POWER_EN] & (d[SYS_FORCED_TONE_BIT] | toneKeyIn)});
	endtask
	task automatic doRead(input logic [1:0] s);
		logic a;
		logic [7:0] b0, b1;
		logic [1:0] fl;
		fl = 2'($urandom);
		@(posedge clk);
		overTempIn <= fl[1];
		overLoadIn <= fl[0];
		clks(100);
		host_u.start();
		host_u.wrByte(addrByte(s, 1'b1), a);
		chk({7'h00, a}, 8'h01);
		host_u.rdByte(1'b1, b0);
		host_u.rdByte(1'b0, b1);
		host_u.stop();
		chk(b0, {expCtrl, fl});
		chk(b1, {expCtrl, fl});
	endtask
	initial begin
		logic a;
		logic [1:0] ks;
		void'($urandom(31));
		clks(12);
		resetn <= 1'b1;
		clks(2);
		chk({ctrlBits, sdaOe, bypassClose}, 8'h01);
		clks(100);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			addrSel <= 2'(s);
			doWrite(2'(s), 8'($urandom));
			doRead(2'(s));
			$display("address test %0d done", s);
		end
		host_u.start();
		host_u.wrByte(addrByte(2'h1, 1'b0), a);
		chk({7'h00, a}, 8'h00);
		host_u.stop();
		$display("wrong address test done");
		for (int f = 0; f < 2; f++) begin
			doWrite(2'h3, {2'($urandom), 1'(f), 2'($urandom), 1'b1, 2'h0});
			for (int k = 0; k < 4; k++) begin
				ks = 2'(k);
				@(posedge clk);
				toneKeyIn <= ks[1];
				toneSenseIn <= ks[0];
				clks(10);
				chk({7'h00, toneCarrierOn}, {7'h00, 1'(f) | ks[1]});
				chk({6'h00, toneDetectOe, toneDetectOut}, {6'h00, ks[0], 1'b0});
			end
		end
		$display("tone test done");
		@(posedge clk);
		uvloIn <= 1'b1;
		clks(100);
		host_u.start();
		host_u.wrByte(addrByte(2'h3, 1'b0), a);
		chk({7'h00, a}, 8'h00);
		host_u.stop();
		expCtrl = 6'h00;
		chk({2'h0, ctrlBits}, 8'h00);
		@(posedge clk);
		uvloIn <= 1'b0;
		clks(100);
		doRead(2'h3);
		$display("undervoltage test done");
		give_verdict();
	end
	initial begin
		#950000;
		n_errors++;
		give_verdict();
	end
endmodule
